// ===== cpu_sfr_params.svh
// Offsets, field positions, reset values and widths of the core registers
`ifndef CPU_SFR_PARAMS_SVH
`define CPU_SFR_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_PC_LOW 5'h02
`define IDX_FLAGS 5'h03
`define IDX_PTRA_LO 5'h04
`define IDX_PTRA_HI 5'h05
`define IDX_PTRB_LO 5'h06
`define IDX_PTRB_HI 5'h07
`define IDX_BANK 5'h08
`define IDX_WACC 5'h09
`define IDX_PC_LATCH 5'h0A
`define IDX_EVT_STAT 5'h10
`define IDX_EVT_CLR 5'h11
`define IDX_EVT_EN 5'h12

// ==========================================================
// Flag positions inside the core flags register
`define FLAG_TO 4
`define FLAG_PD 3
`define FLAG_Z 2
`define FLAG_DC 1
`define FLAG_C 0

// ==========================================================
// Event bit positions
`define EVT_WDT 0
`define EVT_SLEEP 1
`define EVT_CALL 2
`define EVT_SUPPRESS 3
`define EVT_W 4

// ==========================================================
// Reset values
`define FLAGS_RST 5'h18
`define PC_LOW_RST 8'h00
`define PCU_RST 7'h00
`define PTR_RST 16'h0000
`define BANK_RST 6'h00
`define WACC_RST 8'h00
`define PC_LATCH_RST 7'h00

// ==========================================================
// Addressing constants
`define WIN_A_OFS 7'h00
`define WIN_B_OFS 7'h01
`define LINEAR_BASE 16'h2000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== cpu_sfr_pkg.sv
// Types shared by the core special register block
package cpu_sfr_pkg;
	// ==========================================================
	// Arithmetic and logic operations reported by the core
	typedef enum logic [2:0] {
		ALU_NONE = 3'h0,
		ALU_ADD = 3'h1,
		ALU_SUB = 3'h2,
		ALU_AND = 3'h3,
		ALU_OR = 3'h4,
		ALU_XOR = 3'h5,
		ALU_ROTL = 3'h6,
		ALU_ROTR = 3'h7
	} aluOp_t;

	// Data memory address source
	typedef enum logic [1:0] {
		MEM_DIRECT = 2'h0,
		MEM_PTR_A = 2'h1,
		MEM_PTR_B = 2'h2
	} memMode_t;

	// Bus write sequence, Gray coded
	typedef enum logic [1:0] {
		W_IDLE = 2'h0,
		W_TAKE = 2'h1,
		W_COMMIT = 2'h3,
		W_RESP = 2'h2
	} wrState_t;
endpackage

// ===== flag_unit.sv
// Arithmetic result and flag computation
`timescale 1ns/1ps
`include "cpu_sfr_params.svh"

module flag_unit
	import cpu_sfr_pkg::*;
(
	input wire aluOp_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] res,
	output logic z,
	output logic dc,
	output logic c,
	output logic updZ,
	output logic updCarry
);
	// Second operand after complementing for subtraction
	logic [7:0] bOp;
	logic cIn;
	logic [8:0] sum;
	logic [4:0] nib;

	// ==========================================================
	// Adder shared by add and subtract
	always_comb begin
		// Subtract adds the two's complement: carries read as not-borrow
		bOp = (op == ALU_SUB) ? ~b : b;
		cIn = (op == ALU_SUB);
		sum = {1'b0, a} + {1'b0, bOp} + {8'h00, cIn};
		nib = {1'b0, a[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cIn};
	end

	// ==========================================================
	// Result and flags per operation
	always_comb begin
		res = 8'h00;
		dc = 1'b0;
		c = cin;
		updCarry = 1'b0;
		updZ = 1'b1;
		unique case (op)
			ALU_ADD, ALU_SUB: begin
				res = sum[7:0];
				dc = nib[4];
				c = sum[8];
				updCarry = 1'b1;
			end
			ALU_AND: res = a & b;
			ALU_OR: res = a | b;
			ALU_XOR: res = a ^ b;
			ALU_ROTL: begin
				// Rotates touch only the carry
				res = {a[6:0], cin};
				c = a[7];
				updZ = 1'b0;
			end
			ALU_ROTR: begin
				res = {cin, a[7:1]};
				c = a[0];
				updZ = 1'b0;
			end
			ALU_NONE: updZ = 1'b0;
		endcase
		z = (res == 8'h00);
	end
endmodule

// ===== addr_resolver.sv
// Data memory address formation, direct or through a pointer
`timescale 1ns/1ps
`include "cpu_sfr_params.svh"

module addr_resolver
	import cpu_sfr_pkg::*;
(
	input wire memMode_t mode,
	input wire logic [6:0] offset,
	input wire logic [5:0] bank,
	input wire logic [15:0] ptrA,
	input wire logic [15:0] ptrB,
	output logic [15:0] addr,
	output logic windowHit
);
	// ==========================================================
	// Source selection and window detection
	always_comb begin
		unique case (mode)
			MEM_PTR_A: addr = ptrA;
			MEM_PTR_B: addr = ptrB;
			default: addr = {3'h0, bank, offset};
		endcase
		// Banked space mirrors the window pair at the base of every bank
		windowHit = (mode != MEM_DIRECT) && (addr < `LINEAR_BASE) &&
			(addr[6:0] == `WIN_A_OFS || addr[6:0] == `WIN_B_OFS);
	end
endmodule

// ===== cpu_sfr_block.sv
// Core special registers with an AXI4-Lite register port
`timescale 1ns/1ps
`include "cpu_sfr_params.svh"

module cpu_sfr_block
	import cpu_sfr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic powerOnReset,
	input wire logic wdtResetCause,
	input wire logic aluValid,
	input wire aluOp_t aluOp,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	input wire logic watchdogClearOp,
	input wire logic sleepOp,
	input wire logic watchdogTimeout,
	input wire logic computedCallOp,
	input wire logic pcLoad,
	input wire logic [14:0] pcNext,
	input wire logic coreWrEn,
	input wire logic [4:0] coreWrIdx,
	input wire logic [7:0] coreWrData,
	input wire logic memReq,
	input wire memMode_t memMode,
	input wire logic [6:0] memOffset,
	input wire logic memWrite,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq,
	output logic [7:0] pcLow,
	output logic [6:0] pcUpper,
	output logic [7:0] flags,
	output logic [7:0] wacc,
	output logic [7:0] aluResult,
	output logic [15:0] memAddr,
	output logic memValid,
	output logic memWrEn,
	output logic memRdZero
);
	// ==========================================================
	// Storage
	logic [7:0] pcLow_q; // Program counter low byte
	logic [6:0] pcUpper_q; // Program counter upper bits
	logic [4:0] flags_q; // Timeout, power-down, Z, DC, C
	logic [15:0] ptrA_q;
	logic [15:0] ptrB_q;
	logic [5:0] bank_q;
	logic [7:0] wacc_q;
	logic [6:0] pcLatch_q; // Upper PC holding latch
	logic [3:0] evtStat_q; // Sticky event bits
	logic [3:0] evtEn_q;
	logic irq_q;
	logic [7:0] aluResult_q;
	logic [15:0] memAddr_q;
	logic memValid_q, memWrEn_q, memRdZero_q;
	// Bus state
	wrState_t wrState_q;
	logic [7:0] wAddr_q;
	logic [7:0] wData_q;
	logic wStrb_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Unified register write port
	logic wrEn;
	logic [4:0] wrIdx;
	logic [7:0] wrData;
	logic busCommit;
	// Sub-block results
	logic [7:0] fuRes;
	logic fuZ, fuDc, fuC, fuUpdZ, fuUpdC;
	logic [15:0] resAddr;
	logic resHit;
	logic [3:0] evtSet, evtClr;

	// ==========================================================
	// Shared decode helpers
	function automatic logic isMapped(input logic [7:0] a);
		logic [4:0] i;
		i = a[6:2];
		isMapped = !a[7] && ((i >= `IDX_PC_LOW && i <= `IDX_PC_LATCH) ||
			(i >= `IDX_EVT_STAT && i <= `IDX_EVT_EN));
	endfunction

	function automatic logic [7:0] readReg(input logic [4:0] i);
		unique case (i)
			`IDX_PC_LOW: readReg = pcLow_q;
			`IDX_FLAGS: readReg = {3'h0, flags_q};
			`IDX_PTRA_LO: readReg = ptrA_q[7:0];
			`IDX_PTRA_HI: readReg = ptrA_q[15:8];
			`IDX_PTRB_LO: readReg = ptrB_q[7:0];
			`IDX_PTRB_HI: readReg = ptrB_q[15:8];
			`IDX_BANK: readReg = {2'h0, bank_q};
			`IDX_WACC: readReg = wacc_q;
			`IDX_PC_LATCH: readReg = {1'b0, pcLatch_q};
			`IDX_EVT_STAT: readReg = {4'h0, evtStat_q};
			`IDX_EVT_EN: readReg = {4'h0, evtEn_q};
			default: readReg = 8'h00; // Clear register reads zero
		endcase
	endfunction

	// ==========================================================
	// Sub-blocks
	flag_unit uFlag (
		.op(aluOp),
		.a(aluA),
		.b(aluB),
		.cin(flags_q[`FLAG_C]),
		.res(fuRes),
		.z(fuZ),
		.dc(fuDc),
		.c(fuC),
		.updZ(fuUpdZ),
		.updCarry(fuUpdC)
	);

	addr_resolver uAddr (
		.mode(memMode),
		.offset(memOffset),
		.bank(bank_q),
		.ptrA(ptrA_q),
		.ptrB(ptrB_q),
		.addr(resAddr),
		.windowHit(resHit)
	);

	// ==========================================================
	// Write port: the core wins, a pending bus write waits while coreWrEn is high
	assign busCommit = (wrState_q == W_COMMIT) && !coreWrEn;
	always_comb begin
		wrEn = coreWrEn || (busCommit && wStrb_q && isMapped(wAddr_q));
		wrIdx = coreWrEn ? coreWrIdx : wAddr_q[6:2];
		wrData = coreWrEn ? coreWrData : wData_q;
	end

	// ==========================================================
	// Program counter
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pcLow_q <= `PC_LOW_RST;
			pcUpper_q <= `PCU_RST;
		end else if (computedCallOp) begin
			pcLow_q <= wacc_q;
			pcUpper_q <= pcLatch_q;
		end else if (pcLoad) begin
			pcLow_q <= pcNext[7:0];
			pcUpper_q <= pcNext[14:8];
		end else if (wrEn && wrIdx == `IDX_PC_LOW) begin
			// A low byte write is a jump: upper bits come from the latch
			pcLow_q <= wrData;
			pcUpper_q <= pcLatch_q;
		end
	end

	// ==========================================================
	// Status flags in one process so the register has a single driver
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			// Warm resets leave the arithmetic bits untouched
			if (powerOnReset) begin
				flags_q <= `FLAGS_RST;
			end else if (wdtResetCause) begin
				flags_q[`FLAG_TO] <= 1'b0;
			end
		end else begin
			// Expiry beats sleep, which beats a clear op
			if (watchdogTimeout) begin
				flags_q[`FLAG_TO] <= 1'b0;
			end else if (sleepOp) begin
				flags_q[`FLAG_TO] <= 1'b1;
				flags_q[`FLAG_PD] <= 1'b0;
			end else if (watchdogClearOp) begin
				flags_q[`FLAG_TO] <= 1'b1;
				flags_q[`FLAG_PD] <= 1'b1;
			end
			// Software reaches only the arithmetic bits
			if (wrEn && wrIdx == `IDX_FLAGS)
				flags_q[2:0] <= wrData[2:0];
			// An instruction result overrides a same-cycle write
			if (aluValid && fuUpdZ)
				flags_q[`FLAG_Z] <= fuZ;
			if (aluValid && fuUpdC) begin
				flags_q[`FLAG_DC] <= fuDc;
				flags_q[`FLAG_C] <= fuC;
			end else if (aluValid && aluOp inside {ALU_ROTL, ALU_ROTR}) begin
				flags_q[`FLAG_C] <= fuC;
			end
		end
	end

	// Result handed back to the core
	always_ff @(posedge mclk) begin
		if (!rst_b)
			aluResult_q <= 8'h00;
		else if (aluValid)
			aluResult_q <= fuRes;
	end

	// ==========================================================
	// Indirect pointers, byte-wise
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ptrA_q <= `PTR_RST;
			ptrB_q <= `PTR_RST;
		end else if (wrEn) begin
			unique case (wrIdx)
				`IDX_PTRA_LO: ptrA_q[7:0] <= wrData;
				`IDX_PTRA_HI: ptrA_q[15:8] <= wrData;
				`IDX_PTRB_LO: ptrB_q[7:0] <= wrData;
				`IDX_PTRB_HI: ptrB_q[15:8] <= wrData;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Bank, accumulator and upper latch; unused bits are dropped
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bank_q <= `BANK_RST;
			wacc_q <= `WACC_RST;
			pcLatch_q <= `PC_LATCH_RST;
		end else if (wrEn) begin
			if (wrIdx == `IDX_BANK)
				bank_q <= wrData[5:0];
			if (wrIdx == `IDX_WACC)
				wacc_q <= wrData;
			if (wrIdx == `IDX_PC_LATCH)
				pcLatch_q <= wrData[6:0];
		end
	end

	// ==========================================================
	// Data memory request; window self-reference is neutralised
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			memAddr_q <= 16'h0000;
			memValid_q <= 1'b0;
			memWrEn_q <= 1'b0;
			memRdZero_q <= 1'b0;
		end else begin
			memValid_q <= memReq;
			memWrEn_q <= memReq && memWrite && !resHit;
			memRdZero_q <= memReq && !memWrite && resHit;
			if (memReq)
				memAddr_q <= resAddr;
		end
	end

	// ==========================================================
	// Events: set wins over a same-cycle clear
	assign evtSet = {memReq && resHit, computedCallOp, sleepOp,
		watchdogTimeout};
	assign evtClr = (wrEn && wrIdx == `IDX_EVT_CLR) ? wrData[3:0] : 4'h0;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			evtStat_q <= 4'h0;
			evtEn_q <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			evtStat_q <= (evtStat_q & ~evtClr) | evtSet;
			if (wrEn && wrIdx == `IDX_EVT_EN)
				evtEn_q <= wrData[3:0];
			// One cycle behind the status bits
			irq_q <= |(evtStat_q & evtEn_q);
		end
	end

	// ==========================================================
	// AXI4-Lite write channel
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wrState_q <= W_IDLE;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			wAddr_q <= 8'h00;
			wData_q <= 8'h00;
			wStrb_q <= 1'b0;
		end else begin
			unique case (wrState_q)
				W_IDLE: if (awvalid && wvalid) begin
					awready_q <= 1'b1;
					wready_q <= 1'b1;
					wrState_q <= W_TAKE;
				end
				W_TAKE: begin
					// Both channels hand over at this edge
					awready_q <= 1'b0;
					wready_q <= 1'b0;
					wAddr_q <= awaddr;
					wData_q <= wdata[7:0];
					wStrb_q <= wstrb[0];
					wrState_q <= W_COMMIT;
				end
				W_COMMIT: if (busCommit) begin
					bvalid_q <= 1'b1;
					bresp_q <= isMapped(wAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
					wrState_q <= W_RESP;
				end
				W_RESP: if (bready) begin
					bvalid_q <= 1'b0;
					wrState_q <= W_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, isMapped(araddr) ?
				readReg(araddr[6:2]) : 8'h00};
			rresp_q <= isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_q) begin
			if (rready)
				rvalid_q <= 1'b0;
		end else if (arvalid) begin
			arready_q <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign irq = irq_q;
	assign pcLow = pcLow_q;
	assign pcUpper = pcUpper_q;
	assign flags = {3'h0, flags_q};
	assign wacc = wacc_q;
	assign aluResult = aluResult_q;
	assign memAddr = memAddr_q;
	assign memValid = memValid_q;
	assign memWrEn = memWrEn_q;
	assign memRdZero = memRdZero_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [8:0] chkSum;
	assign chkSum = {1'b0, aluA} + {1'b0, aluB};
	logic noPcCtl;
	assign noPcCtl = !computedCallOp && !pcLoad;

	chk_pcl_write: assert property (
		wrEn && wrIdx == `IDX_PC_LOW && noPcCtl |=> pcLow_q == $past(wrData))
		else $error("pc low byte write lost");
	chk_to_expiry: assert property (
		watchdogTimeout |=> !flags_q[`FLAG_TO] [*1] ##0 flags[4] == 1'b0)
		else $error("timeout flag not cleared");
	chk_pd_sleep: assert property (
		sleepOp && !watchdogTimeout |=> !flags_q[`FLAG_PD] && flags_q[4])
		else $error("sleep flag update wrong");
	chk_por_flags: assert property (@(posedge mclk) disable iff (1'b0)
		!rst_b && powerOnReset |=> flags_q == `FLAGS_RST)
		else $error("power-on flags wrong");
	chk_warm_keep: assert property (@(posedge mclk) disable iff (1'b0)
		!rst_b && !powerOnReset |=> $stable(flags_q[2:0]))
		else $error("arithmetic flags changed on warm reset");
	chk_zero_flag: assert property (
		aluValid && aluOp == ALU_XOR |=> flags_q[2] == (aluResult_q == 8'h00))
		else $error("zero flag mismatch");
	chk_add_carry: assert property (
		aluValid && aluOp == ALU_ADD |=> flags_q[0] == $past(chkSum[8]))
		else $error("add carry mismatch");
	chk_rotate_carry: assert property (
		aluValid && aluOp == ALU_ROTR |=> flags_q[0] == $past(aluA[0]))
		else $error("rotate carry mismatch");
	chk_latch_only: assert property (
		wrEn && wrIdx == `IDX_PC_LATCH && noPcCtl |=> $stable(pcUpper_q))
		else $error("latch write moved the pc");
	chk_call_load: assert property (
		computedCallOp |=> pcLow_q == $past(wacc_q) &&
		pcUpper_q == $past(pcLatch_q))
		else $error("computed call load wrong");
	chk_window_block: assert property (
		memReq && memWrite && resHit |=> memValid_q && !memWrEn_q)
		else $error("window write not suppressed");
	chk_bus_answer: assert property (
		wrState_q == W_TAKE |-> ##[1:8] bvalid_q)
		else $error("write response late");

	cov_call: cover property (computedCallOp ##1 wrEn);
	cov_window_read: cover property (memRdZero_q);
	cov_bus_write: cover property (busCommit ##1 bvalid_q && bready);
	cov_irq: cover property (irq_q);
endmodule

// ===== testbench.sv
// Self-checking bench for the core special register block
`timescale 1ns/1ps
`include "cpu_sfr_params.svh"

module testbench
	import cpu_sfr_pkg::*;
;
	// ====================
	// Stimulus and observed signals
	logic mclk, rst_b, powerOnReset, wdtResetCause, aluValid, pcLoad;
	aluOp_t aluOp;
	logic [7:0] aluA, aluB, coreWrData, awaddr, araddr;
	logic [3:0] ops; // Clear, sleep, expiry, computed call
	logic [14:0] pcNext;
	logic coreWrEn, memReq, memWrite, awvalid, wvalid;
	logic bready, arvalid, rready;
	logic [4:0] coreWrIdx;
	memMode_t memMode;
	logic [6:0] memOffset, pcUpper;
	logic [31:0] wdata, rdata, rd; // Rd holds the last read word
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic memValid, memWrEn, memRdZero;
	logic [1:0] bresp, rresp, rsp; // Rsp holds the last response
	logic [7:0] pcLow, flags, wacc, aluResult;
	logic [15:0] memAddr;
	int nFail, numChecks;

	cpu_sfr_block dut (
		.mclk(mclk), .rst_b(rst_b), .powerOnReset(powerOnReset),
		.wdtResetCause(wdtResetCause), .aluValid(aluValid), .aluOp(aluOp),
		.aluA(aluA), .aluB(aluB), .watchdogClearOp(ops[0]),
		.sleepOp(ops[1]), .watchdogTimeout(ops[2]), .computedCallOp(ops[3]),
		.pcLoad(pcLoad), .pcNext(pcNext), .coreWrEn(coreWrEn),
		.coreWrIdx(coreWrIdx), .coreWrData(coreWrData), .memReq(memReq),
		.memMode(memMode), .memOffset(memOffset), .memWrite(memWrite),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq), .pcLow(pcLow),
		.pcUpper(pcUpper), .flags(flags), .wacc(wacc),
		.aluResult(aluResult), .memAddr(memAddr), .memValid(memValid),
		.memWrEn(memWrEn), .memRdZero(memRdZero)
	);

	// ====================
	// Case tables
	typedef struct {
		logic [4:0] idx;
		logic [7:0] rst, wr, exp;
	} regRow_t;
	typedef struct {
		aluOp_t op;
		logic [7:0] a, b, res, flg;
	} aluRow_t;
	// Reset value, written byte, byte read back
	regRow_t regRows[9] = '{
		'{`IDX_PC_LOW, 8'h00, 8'hA5, 8'hA5}, '{`IDX_FLAGS, 8'h18, 8'hFF, 8'h1F},
		'{`IDX_PTRA_LO, 8'h00, 8'h34, 8'h34}, '{`IDX_PTRA_HI, 8'h00, 8'h12, 8'h12},
		'{`IDX_PTRB_LO, 8'h00, 8'h78, 8'h78}, '{`IDX_PTRB_HI, 8'h00, 8'h56, 8'h56},
		'{`IDX_BANK, 8'h00, 8'hFF, 8'h3F}, '{`IDX_WACC, 8'h00, 8'h5A, 8'h5A},
		'{`IDX_PC_LATCH, 8'h00, 8'hFF, 8'h7F}};
	// Flags chain from row to row, so order matters
	aluRow_t aluRows[12] = '{
		'{ALU_ADD, 8'h0F, 8'h01, 8'h10, 8'h1A},
		'{ALU_ADD, 8'hF0, 8'h10, 8'h00, 8'h1D},
		'{ALU_SUB, 8'h05, 8'h03, 8'h02, 8'h1B},
		'{ALU_SUB, 8'h03, 8'h05, 8'hFE, 8'h18},
		'{ALU_SUB, 8'h10, 8'h01, 8'h0F, 8'h19},
		'{ALU_AND, 8'hF0, 8'h0F, 8'h00, 8'h1D},
		'{ALU_XOR, 8'hAA, 8'h55, 8'hFF, 8'h19},
		'{ALU_OR, 8'h80, 8'h01, 8'h81, 8'h19},
		'{ALU_ROTL, 8'h01, 8'h00, 8'h03, 8'h18},
		'{ALU_ROTR, 8'h01, 8'h00, 8'h00, 8'h19},
		'{ALU_ROTR, 8'h02, 8'h00, 8'h81, 8'h18},
		'{ALU_NONE, 8'h00, 8'h00, 8'h00, 8'h18}};

	// ====================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Bus write; bready rises after the address edge to avoid a double drive
	task automatic axiWr(input logic [4:0] idx, input logic [31:0] d,
		input logic [3:0] s);
		awaddr <= {1'b0, idx, 2'b00};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge mclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge mclk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	// Bus read; data and response taken at the rvalid edge
	task automatic axiRd(input logic [4:0] idx);
		araddr <= {1'b0, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge mclk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdChk(input logic [4:0] idx, input logic [31:0] exp);
		axiRd(idx);
		check("read data", rd, exp);
		check("read resp", rsp, `RESP_OKAY);
	endtask

	// One core event pulse, result visible after the next edge
	task automatic pulseOps(input logic [3:0] v);
		ops <= v;
		tick(1);
		ops <= 4'h0;
		tick(1);
	endtask

	task automatic memTry(input memMode_t m, input logic w,
		input logic [15:0] a, input logic ew, input logic ez);
		memReq <= 1'b1;
		memMode <= m;
		memWrite <= w;
		memOffset <= 7'h55;
		tick(1);
		memReq <= 1'b0;
		tick(1);
		check("memValid", memValid, 1'b1);
		check("memAddr", memAddr, a);
		check("memWrEn", memWrEn, ew);
		check("memRdZero", memRdZero, ez);
	endtask

	// Reset of a chosen cause, held three edges
	task automatic doReset(input logic por, input logic wdt);
		rst_b <= 1'b0;
		powerOnReset <= por;
		wdtResetCause <= wdt;
		tick(3);
		rst_b <= 1'b1;
		powerOnReset <= 1'b0;
		wdtResetCause <= 1'b0;
		tick(1);
	endtask

	task automatic results;
		if (nFail == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ====================
	// Clock, 5 ns period
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Watchdog; the full run needs well under this many cycles
	initial begin
		tick(20000);
		nFail++;
		results();
	end

	// ====================
	// Main sequence
	initial begin
		{rst_b, wdtResetCause, aluValid, pcLoad, coreWrEn, memReq} = '0;
		{memWrite, awvalid, wvalid, bready, arvalid, rready} = '0;
		{aluA, aluB, coreWrData, awaddr, araddr, wdata} = '0;
		{ops, pcNext, coreWrIdx, memOffset, wstrb} = '0;
		powerOnReset = 1'b1;
		aluOp = ALU_NONE;
		memMode = MEM_DIRECT;
		nFail = 0;
		numChecks = 0;
		tick(12);
		rst_b <= 1'b1;
		powerOnReset <= 1'b0;
		tick(1);
		check("flags", flags, 8'h18);
		check("irq", irq, 1'b0);
		// Reset value, write, read back; upper bus bits must read zero
		foreach (regRows[i]) begin
			rdChk(regRows[i].idx, regRows[i].rst);
			axiWr(regRows[i].idx, {24'hABCDEF, regRows[i].wr}, 4'hF);
			check("write resp", rsp, `RESP_OKAY);
			rdChk(regRows[i].idx, regRows[i].exp);
		end
		axiWr(`IDX_FLAGS, 32'h0, 4'hF);
		foreach (aluRows[i]) begin
			aluValid <= 1'b1;
			aluOp <= aluRows[i].op;
			aluA <= aluRows[i].a;
			aluB <= aluRows[i].b;
			tick(1);
			aluValid <= 1'b0;
			tick(1);
			check("aluResult", aluResult, aluRows[i].res);
			check("flags", flags, aluRows[i].flg);
		end
		// Expiry, sleep and clear on the two read-only flags
		pulseOps(4'h4);
		check("flags", flags, 8'h08);
		pulseOps(4'h2);
		check("flags", flags, 8'h10);
		pulseOps(4'h1);
		check("flags", flags, 8'h18);
		// Sticky events, enable, mask and clear
		axiRd(`IDX_EVT_STAT);
		check("status", rd[3:0], 4'h3);
		axiWr(`IDX_EVT_EN, 32'h1, 4'hF);
		tick(2);
		check("irq", irq, 1'b1);
		axiWr(`IDX_EVT_STAT, 32'h0, 4'hF);
		axiWr(`IDX_EVT_CLR, 32'h1, 4'hF);
		tick(2);
		check("irq", irq, 1'b0);
		axiRd(`IDX_EVT_STAT);
		check("status", rd[3:0], 4'h2);
		axiWr(`IDX_EVT_CLR, 32'h2, 4'hF);
		// Core write, computed call, direct load, latch alone, low byte
		coreWrEn <= 1'b1;
		coreWrIdx <= `IDX_WACC;
		coreWrData <= 8'hC3;
		tick(1);
		coreWrEn <= 1'b0;
		tick(1);
		check("wacc", wacc, 8'hC3);
		pulseOps(4'h8);
		check("pcLow", pcLow, 8'hC3);
		check("pcUpper", pcUpper, 7'h7F);
		pcLoad <= 1'b1;
		pcNext <= 15'h1234;
		tick(1);
		pcLoad <= 1'b0;
		tick(1);
		check("pcUpper", pcUpper, 7'h12);
		axiWr(`IDX_PC_LATCH, 32'h11, 4'hF);
		check("pcUpper", pcUpper, 7'h12);
		axiWr(`IDX_PC_LOW, 32'h99, 4'hF);
		tick(1);
		check("pcLow", pcLow, 8'h99);
		check("pcUpper", pcUpper, 7'h11);
		// Data memory address forming, including window hits
		memTry(MEM_DIRECT, 1'b1, 16'h1FD5, 1'b1, 1'b0);
		memTry(MEM_PTR_A, 1'b0, 16'h1234, 1'b0, 1'b0);
		memTry(MEM_PTR_B, 1'b1, 16'h5678, 1'b1, 1'b0);
		axiWr(`IDX_PTRA_LO, 32'h01, 4'hF);
		axiWr(`IDX_PTRA_HI, 32'h00, 4'hF);
		axiWr(`IDX_PTRB_LO, 32'h80, 4'hF);
		axiWr(`IDX_PTRB_HI, 32'h00, 4'hF);
		memTry(MEM_PTR_A, 1'b0, 16'h0001, 1'b0, 1'b1);
		memTry(MEM_PTR_B, 1'b1, 16'h0080, 1'b0, 1'b0);
		axiRd(`IDX_EVT_STAT);
		check("status", rd[3:0], 4'hC);
		// Refusals: unmapped place and empty strobe
		axiRd(5'h1F);
		check("unmapped resp", rsp, `RESP_SLVERR);
		check("unmapped data", rd, 32'h0);
		axiWr(5'h1F, 32'h1, 4'hF);
		check("unmapped resp", rsp, `RESP_SLVERR);
		axiWr(`IDX_WACC, 32'h77, 4'h0);
		check("strobe resp", rsp, `RESP_OKAY);
		rdChk(`IDX_WACC, 32'hC3);
		// Warm resets keep arithmetic flags; only power-on restores all
		axiWr(`IDX_FLAGS, 32'h07, 4'hF);
		doReset(1'b0, 1'b1);
		check("flags", flags, 8'h0F);
		check("pcLow", pcLow, 8'h00);
		doReset(1'b0, 1'b0);
		check("flags", flags, 8'h0F);
		pulseOps(4'h2);
		check("flags", flags, 8'h17);
		doReset(1'b1, 1'b0);
		check("flags", flags, 8'h18);
		results();
	end
endmodule
